//--- vld_cfg.svh
`ifndef VLD_CFG_SVH
`define VLD_CFG_SVH
`define VLD_ADR_CMD 8'h00
`define VLD_ADR_STATUS 8'h04
`define VLD_ADR_IMASK 8'h08
`define VLD_ADR_WINDOW 8'h0c
`define VLD_ADR_FETCH 8'h10
`define VLD_ADR_LEFT 8'h14
`define VLD_ADR_QSCALE 8'h18
`define VLD_ADR_PINFO 8'h1c
`define VLD_ST_DONE 0
`define VLD_ST_START 1
`define VLD_ST_ERROR 2
`define VLD_ST_INDONE 3
`define VLD_ST_OSTALL 4
`define VLD_ST_ISTALL 5
`define VLD_W1C_MASK 6'h3e
`define VLD_WIN_BITS 6'h10
`define VLD_WORD_BITS 6'h20
`define VLD_WORD_BYTES 32'h4
`define VLD_FIFO_LAST 5'h0f
`define VLD_RSIZE_MAX 4'h8
`define VLD_QS_BITS 4'h5
`define VLD_TYPE_BITS 4'h6
`define VLD_MV_BITS 4'h2
`define VLD_DMV_BITS 4'h4
`endif

//--- vld_fifo.sv
`include "vld_cfg.svh"
module vld_fifo (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    // fill side
    input wire logic push_i,
    input wire logic [31:0] wdata_i,
    // drain side
    input wire logic pop_i,
    output logic [31:0] rdata_o,
    output logic empty_o,
    output logic last_o
);
    vld_pkg::vld_fifo_s st;
    vld_pkg::vld_fifo_s next_st;
    logic [4:0] used;

    assign used = st.wptr - st.rptr;
    assign empty_o = (used == 5'h00);
    assign last_o = (used == `VLD_FIFO_LAST);
    assign rdata_o = st.mem[st.rptr[3:0]];

    // sixty-four bytes as sixteen words
    always_comb
    begin
        next_st = st;
        if (push_i)
        begin
            next_st.mem[st.wptr[3:0]] = wdata_i;
            next_st.wptr = st.wptr + 5'h01;
        end
        if (pop_i)
            next_st.rptr = st.rptr + 5'h01;
        if (clear_i)
            next_st = '0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            st <= '0;
        else
            st <= next_st;
    end
endmodule // vld_fifo

//--- vld_hdr.sv
module vld_hdr (
    // decoded fields
    input wire vld_pkg::vld_hdr_s f_i,
    // packed header word
    output logic [31:0] word_o
);
    logic [7:0] keep;

    always_comb
    begin
        keep = ~(8'hff >> f_i.rsize);
        // five msb of type, count minus one, left-justified residual with only its top rsize bits kept
        word_o = {f_i.quant, f_i.mb_type[5:1], f_i.mv_tab - 2'h1,
            f_i.dmv1, f_i.dmv0, f_i.resid_raw & keep, 8'h00};
    end
endmodule // vld_hdr

//--- vld_mem_model.sv
module vld_mem_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // fetch port
    input wire logic req_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] gap_i,
    output logic ack_o,
    output logic [31:0] data_o,
    output logic [7:0] acks_o
);
    logic [3:0] wait_n;
    // ************
    // memory reply
    // ************
    always_ff @(posedge clk_i)
    begin
        ack_o <= 1'b0;
        data_o <= ~data_o;
        if (rst_i)
        begin
            wait_n <= 4'h0;
            acks_o <= 8'h0;
            data_o <= 32'h5a5a5a5a;
        end
        else if (req_i && !ack_o && wait_n >= gap_i)
        begin
            ack_o <= 1'b1;
            wait_n <= 4'h0;
            acks_o <= acks_o + 8'h1;
            // words with address bit 9 set read as zero
            data_o <= adr_i[9] ? 32'h0 :
                {~adr_i[15:0], adr_i[15:0] ^ 16'hb6d1};
        end
        else if (req_i)
        begin
            wait_n <= wait_n + 4'h1;
        end
    end
endmodule // vld_mem_model

//--- vld_pkg.sv
package vld_pkg;
    typedef enum logic [3:0] {
        VLD_OP_NONE = 4'h0,
        VLD_OP_SHIFT = 4'h1,
        VLD_OP_SEARCH = 4'h2,
        VLD_OP_RESET = 4'h3,
        VLD_OP_PARSE = 4'h4,
        VLD_OP_FLUSH = 4'h5
    } vld_op_e;
    typedef enum logic [3:0] {
        VLD_IDLE = 4'h0,
        VLD_SHIFT = 4'h1,
        VLD_SEARCH = 4'h2,
        VLD_P_START = 4'h3,
        VLD_P_QS = 4'h4,
        VLD_P_TYPE = 4'h5,
        VLD_P_MV = 4'h6,
        VLD_P_DMV = 4'h7,
        VLD_P_RES = 4'h8,
        VLD_P_EMIT = 4'h9
    } vld_state_e;
    typedef struct packed {
        logic [4:0] quant;
        logic [5:0] mb_type;
        logic [1:0] mv_tab;
        logic [1:0] dmv1;
        logic [1:0] dmv0;
        logic [7:0] resid_raw;
        logic [3:0] rsize;
    } vld_hdr_s;
    typedef struct packed {
        logic [15:0][31:0] mem;
        logic [4:0] wptr;
        logic [4:0] rptr;
    } vld_fifo_s;
    typedef struct packed {
        vld_state_e st;
        logic [47:0] bits;
        logic [5:0] nbits;
        logic [3:0] amt;
        logic [7:0] mb_left;
        vld_hdr_s f;
        logic [5:0] status;
        logic [5:0] imask;
        logic [31:0] fetch_adr;
        logic [31:0] bytes_left;
        logic [4:0] qscale;
        logic [3:0] pinfo;
        logic ack;
        logic [31:0] dat;
        logic irq;
        logic mem_req;
        logic hdr_valid;
        logic [31:0] hdr_word;
        logic flush;
    } vld_top_s;
endpackage

//--- vld_top.sv
// Implementation choices: the Wishbone register port and the register offsets.
`include "vld_cfg.svh"

module vld_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // interrupt
    output logic irq_o,
    // input fetch from memory
    output logic mem_req_o,
    output logic [31:0] mem_adr_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_data_i,
    // header output stream
    output logic hdr_valid_o,
    output logic [31:0] hdr_word_o,
    input wire logic hdr_ready_i,
    output logic flush_o
);
    vld_pkg::vld_top_s r;
    vld_pkg::vld_top_s next_r;
    vld_pkg::vld_op_e op;
    logic fifo_empty;
    logic fifo_last;
    logic refill;
    logic ok;
    logic do_cons;
    logic wb_req;
    logic wr;
    logic cmd_wr;
    logic cmd_reset;
    logic rd_win;
    logic [3:0] cons_n;
    logic [3:0] rsize;
    logic [5:0] clr;
    logic [31:0] fifo_data;
    logic [31:0] wmask;
    logic [31:0] hdr_w;
    logic [31:0] left_dec;
    logic [15:0] window;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [31:0] m);
        merge = (old & ~m) | (d & m);
    endfunction

    // ********************************
    // bus decode
    // ********************************
    assign window = r.bits[47:32];
    assign wb_req = cyc_i & stb_i & ~r.ack;
    assign wr = wb_req & we_i;
    assign rd_win = wb_req & ~we_i & (adr_i == `VLD_ADR_WINDOW);
    assign cmd_wr = wr & (adr_i == `VLD_ADR_CMD) & sel_i[0];
    assign op = vld_pkg::vld_op_e'(dat_i[3:0]);
    assign cmd_reset = cmd_wr & (op == vld_pkg::VLD_OP_RESET);
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
        {8{sel_i[1]}}, {8{sel_i[0]}}};
    assign clr = (wr && adr_i == `VLD_ADR_STATUS) ?
        (dat_i[5:0] & wmask[5:0] & `VLD_W1C_MASK) : 6'h00;
    assign refill = (r.nbits <= `VLD_WIN_BITS) & ~fifo_empty;
    assign ok = (r.nbits >= `VLD_WIN_BITS) & ~refill;
    assign left_dec = (r.bytes_left > `VLD_WORD_BYTES) ?
        r.bytes_left - `VLD_WORD_BYTES : 32'h0;
    assign rsize = (r.pinfo > `VLD_RSIZE_MAX) ? `VLD_RSIZE_MAX : r.pinfo;

    // ********************************
    // submodules
    // ********************************
    vld_fifo u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(cmd_reset),
        .push_i(r.mem_req & mem_ack_i),
        .wdata_i(mem_data_i),
        .pop_i(refill),
        .rdata_o(fifo_data),
        .empty_o(fifo_empty),
        .last_o(fifo_last)
    );

    vld_hdr u_hdr (
        .f_i(r.f),
        .word_o(hdr_w)
    );

    // ********************************
    // next state
    // ********************************
    always_comb
    begin
        next_r = r;
        do_cons = 1'b0;
        cons_n = 4'h0;
        next_r.ack = wb_req;
        next_r.flush = 1'b0;
        next_r.status = r.status & ~clr;
        if (r.hdr_valid && hdr_ready_i)
            next_r.hdr_valid = 1'b0;
        // input fetch
        if (r.mem_req && mem_ack_i)
        begin
            next_r.fetch_adr = r.fetch_adr + `VLD_WORD_BYTES;
            next_r.bytes_left = left_dec;
            if (left_dec == 32'h0)
                next_r.status[`VLD_ST_INDONE] = 1'b1;
            if (left_dec == 32'h0 || fifo_last)
                next_r.mem_req = 1'b0;
        end
        else if (!r.mem_req && fifo_empty && r.bytes_left != 32'h0)
            next_r.mem_req = 1'b1;
        if (r.st != vld_pkg::VLD_IDLE && r.nbits < `VLD_WIN_BITS &&
            fifo_empty && !r.mem_req && r.bytes_left == 32'h0)
            next_r.status[`VLD_ST_ISTALL] = 1'b1;
        // command sequencer, waits while window is short
        case (r.st)
            vld_pkg::VLD_IDLE:
                next_r.st = vld_pkg::VLD_IDLE;
            vld_pkg::VLD_SHIFT:
                if (ok)
                begin
                    do_cons = 1'b1;
                    cons_n = r.amt;
                    next_r.st = vld_pkg::VLD_IDLE;
                    next_r.status[`VLD_ST_DONE] = 1'b1;
                end
            vld_pkg::VLD_SEARCH:
                if (ok)
                begin
                    if (window == 16'h0000)
                    begin
                        next_r.st = vld_pkg::VLD_IDLE;
                        next_r.status[`VLD_ST_DONE] = 1'b1;
                    end
                    else
                    begin
                        do_cons = 1'b1;
                        cons_n = 4'h1;
                    end
                end
            vld_pkg::VLD_P_START:
                if (r.mb_left == 8'h00)
                begin
                    next_r.st = vld_pkg::VLD_IDLE;
                    next_r.status[`VLD_ST_DONE] = 1'b1;
                end
                else if (ok)
                begin
                    if (window == 16'h0000)
                    begin
                        next_r.st = vld_pkg::VLD_IDLE;
                        next_r.status[`VLD_ST_START] = 1'b1;
                    end
                    else
                        next_r.st = vld_pkg::VLD_P_QS;
                end
            vld_pkg::VLD_P_QS:
                if (ok)
                begin
                    do_cons = 1'b1;
                    cons_n = `VLD_QS_BITS;
                    next_r.qscale = window[15:11];
                    next_r.f.quant = window[15:11];
                    next_r.st = vld_pkg::VLD_P_TYPE;
                end
            vld_pkg::VLD_P_TYPE:
                if (ok)
                begin
                    do_cons = 1'b1;
                    cons_n = `VLD_TYPE_BITS;
                    next_r.f.mb_type = window[15:10];
                    if (window[15:10] == 6'h00)
                    begin
                        next_r.st = vld_pkg::VLD_IDLE;
                        next_r.status[`VLD_ST_ERROR] = 1'b1;
                    end
                    else
                        next_r.st = vld_pkg::VLD_P_MV;
                end
            vld_pkg::VLD_P_MV:
                if (ok)
                begin
                    do_cons = 1'b1;
                    cons_n = `VLD_MV_BITS;
                    next_r.f.mv_tab = window[15:14];
                    if (window[15:14] == 2'h0)
                    begin
                        next_r.st = vld_pkg::VLD_IDLE;
                        next_r.status[`VLD_ST_ERROR] = 1'b1;
                    end
                    else
                        next_r.st = vld_pkg::VLD_P_DMV;
                end
            vld_pkg::VLD_P_DMV:
                if (ok)
                begin
                    do_cons = 1'b1;
                    cons_n = `VLD_DMV_BITS;
                    next_r.f.dmv1 = window[15:14];
                    next_r.f.dmv0 = window[13:12];
                    next_r.st = vld_pkg::VLD_P_RES;
                end
            vld_pkg::VLD_P_RES:
                if (ok)
                begin
                    do_cons = 1'b1;
                    cons_n = rsize;
                    next_r.f.rsize = rsize;
                    next_r.f.resid_raw = window[15:8];
                    next_r.st = vld_pkg::VLD_P_EMIT;
                end
            vld_pkg::VLD_P_EMIT:
                if (!r.hdr_valid || hdr_ready_i)
                begin
                    next_r.hdr_valid = 1'b1;
                    next_r.hdr_word = hdr_w;
                    next_r.mb_left = r.mb_left - 8'h01;
                    next_r.st = vld_pkg::VLD_P_START;
                end
                else
                    next_r.status[`VLD_ST_OSTALL] = 1'b1;
            default:
                next_r.st = vld_pkg::VLD_IDLE;
        endcase
        // bitstream buffer: refill or consume, never both
        if (refill)
        begin
            next_r.bits = r.bits | ({fifo_data, 16'h0000} >> r.nbits);
            next_r.nbits = r.nbits + `VLD_WORD_BITS;
        end
        else if (do_cons)
        begin
            next_r.bits = r.bits << cons_n;
            next_r.nbits = r.nbits - {2'b00, cons_n};
        end
        // register writes
        if (wr)
        begin
            case (adr_i)
                `VLD_ADR_CMD:
                    if (sel_i[0])
                    begin
                        next_r.status[`VLD_ST_DONE] = 1'b0;
                        case (op)
                            vld_pkg::VLD_OP_SHIFT:
                            begin
                                next_r.amt = dat_i[7:4];
                                next_r.st = vld_pkg::VLD_SHIFT;
                            end
                            vld_pkg::VLD_OP_SEARCH:
                                next_r.st = vld_pkg::VLD_SEARCH;
                            vld_pkg::VLD_OP_PARSE:
                            begin
                                next_r.mb_left = dat_i[15:8];
                                next_r.st = vld_pkg::VLD_P_START;
                            end
                            vld_pkg::VLD_OP_FLUSH:
                            begin
                                next_r.flush = 1'b1;
                                next_r.status[`VLD_ST_DONE] = 1'b1;
                            end
                            default:
                                next_r.st = r.st;
                        endcase
                    end
                `VLD_ADR_IMASK:
                    next_r.imask = (r.imask & ~wmask[5:0])
                        | (dat_i[5:0] & wmask[5:0]);
                `VLD_ADR_FETCH:
                    next_r.fetch_adr = merge(r.fetch_adr, dat_i, wmask);
                `VLD_ADR_LEFT:
                    next_r.bytes_left = merge(r.bytes_left, dat_i, wmask);
                `VLD_ADR_QSCALE:
                    next_r.qscale = (r.qscale & ~wmask[4:0])
                        | (dat_i[4:0] & wmask[4:0]);
                `VLD_ADR_PINFO:
                    next_r.pinfo = (r.pinfo & ~wmask[3:0])
                        | (dat_i[3:0] & wmask[3:0]);
                default:
                    next_r.ack = wb_req;
            endcase
        end
        // register reads, unmapped reads as zero
        if (wb_req && !we_i)
        begin
            case (adr_i)
                `VLD_ADR_CMD:
                    next_r.dat = {16'h0000, r.mb_left, r.amt, r.st};
                `VLD_ADR_STATUS:
                    next_r.dat = {26'h0, r.status};
                `VLD_ADR_IMASK:
                    next_r.dat = {26'h0, r.imask};
                `VLD_ADR_WINDOW:
                    next_r.dat = {16'h0000, window};
                `VLD_ADR_FETCH:
                    next_r.dat = r.fetch_adr;
                `VLD_ADR_LEFT:
                    next_r.dat = r.bytes_left;
                `VLD_ADR_QSCALE:
                    next_r.dat = {27'h0, r.qscale};
                `VLD_ADR_PINFO:
                    next_r.dat = {28'h0, r.pinfo};
                default:
                    next_r.dat = 32'h0;
            endcase
        end
        if (cmd_reset)
        begin
            next_r = '0;
            next_r.ack = 1'b1;
        end
        next_r.irq = |(next_r.status & next_r.imask);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            r <= '0;
        else
            r <= next_r;
    end

    // ********************************
    // outputs
    // ********************************
    assign dat_o = r.dat;
    assign ack_o = r.ack;
    assign irq_o = r.irq;
    assign mem_req_o = r.mem_req;
    assign mem_adr_o = r.fetch_adr;
    assign hdr_valid_o = r.hdr_valid;
    assign hdr_word_o = r.hdr_word;
    assign flush_o = r.flush;

    // ********************************
    // checks
    // ********************************
    chk_cmd_reset: assert property (
        cmd_reset |=> r.st == vld_pkg::VLD_IDLE && r.status == 6'h00
            && !mem_req_o)
        else $error("reset command did not reinitialise");
    chk_start_halt: assert property (
        r.st == vld_pkg::VLD_P_START && r.mb_left != 8'h00 && ok
            && window == 16'h0000 && !wr
        |=> r.st == vld_pkg::VLD_IDLE && r.status[`VLD_ST_START])
        else $error("start code did not halt with flag");
    chk_err_halt: assert property (
        r.st == vld_pkg::VLD_P_TYPE && ok && window[15:10] == 6'h00
            && !wr
        |=> r.st == vld_pkg::VLD_IDLE && r.status[`VLD_ST_ERROR])
        else $error("bad type did not halt with error");
    chk_shift_count: assert property (
        r.st == vld_pkg::VLD_SHIFT && ok && !cmd_reset
        |=> r.nbits == $past(r.nbits) - {2'b00, $past(r.amt)})
        else $error("shift moved window by wrong count");
    chk_window_read: assert property (
        rd_win |=> ack_o && dat_o == {16'h0000, $past(window)})
        else $error("window read mismatch");
    chk_irq_raise: assert property (
        $rose(r.status[`VLD_ST_START]) && r.imask[`VLD_ST_START]
        |-> irq_o)
        else $error("enabled halt raised no interrupt");
    chk_out_hold: assert property (
        hdr_valid_o && !hdr_ready_i && !cmd_reset
        |=> hdr_valid_o && $stable(hdr_word_o))
        else $error("header word lost while output full");
    chk_fill_empty: assert property (
        $rose(mem_req_o) |-> $past(fifo_empty))
        else $error("fetch started with fifo not empty");
    chk_addr_step: assert property (
        mem_req_o && mem_ack_i && !wr
        |=> mem_adr_o == $past(mem_adr_o) + `VLD_WORD_BYTES)
        else $error("fetch address did not advance");
    chk_in_done: assert property (
        mem_req_o && mem_ack_i && left_dec == 32'h0 && !cmd_reset
        |=> r.status[`VLD_ST_INDONE] && !mem_req_o)
        else $error("input done flag missing");
    chk_done_keep: assert property (
        r.status[`VLD_ST_DONE] && !cmd_wr |=> r.status[`VLD_ST_DONE])
        else $error("done bit cleared without command");
    chk_motion_vector_count: assert property (
        $rose(hdr_valid_o) |-> hdr_word_o[21:20] == r.f.mv_tab - 2'h1
            && hdr_word_o[26:22] == r.f.mb_type[5:1])
        else $error("header count or type field wrong");
endmodule // vld_top

//--- vld_top_tb_top.sv
`include "vld_cfg.svh"
module vld_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i, rst_i, cyc, stb, we, ack, irq, mreq, mack, hval, hrdy, fl;
    logic [7:0] adr, acks;
    logic [3:0] gap;
    logic [31:0] dat, dato, madr, mdat, hword, rd;
    logic [63:0] s;
    int n_mismatch, num_checks, n_flush;
    vld_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dato),
        .ack_o(ack), .irq_o(irq), .mem_req_o(mreq), .mem_adr_o(madr),
        .mem_ack_i(mack), .mem_data_i(mdat), .hdr_valid_o(hval),
        .hdr_word_o(hword), .hdr_ready_i(hrdy), .flush_o(fl));
    vld_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(mreq),
        .adr_i(madr), .gap_i(gap), .ack_o(mack), .data_o(mdat),
        .acks_o(acks));
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        if (fl === 1'b1)
            n_flush++;
    end
    // *************
    // shared tasks
    // *************
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("BAD %s exp %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1);
        rd = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("ack wait", 32'h2, n);
    endtask
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task wait_st(input int b);
        int n;
        n = 0;
        do
        begin
            wb(1'b0, `VLD_ADR_STATUS, 32'h0);
            n++;
        end
        while (rd[b] !== 1'b1 && n < 300);
        chk("status bit", 32'h1, {31'h0, rd[b]});
    endtask
    task chk_irq(input logic e);
        repeat (2) @(posedge clk_i);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    function automatic logic [31:0] w(input logic [15:0] a);
        return {~a, a ^ 16'hb6d1};
    endfunction
    function automatic logic [31:0] hexp(input int o, input int r);
        logic [63:0] t;
        logic [7:0] rs;
        t = s << o;
        rs = t[46:39] & (8'hff << (8 - r));
        return {t[63:59], t[58:54], t[52:51] - 2'h1, t[50:47], rs, 8'h00};
    endfunction
    // *************
    // scenarios
    // *************
    task t_reset;
        rdchk("status", `VLD_ADR_STATUS, 32'h0);
        rdchk("imask", `VLD_ADR_IMASK, 32'h0);
        rdchk("left", `VLD_ADR_LEFT, 32'h0);
        rdchk("unmapped", 8'h20, 32'h0);
        chk_irq(1'b0);
        $display("test reset done");
    endtask
    task t_fetch;
        gap <= 4'h3;
        wb(1'b1, `VLD_ADR_FETCH, 32'h100);
        wb(1'b1, `VLD_ADR_LEFT, 32'h8);
        wait_st(`VLD_ST_INDONE);
        rdchk("fetch", `VLD_ADR_FETCH, 32'h108);
        rdchk("left", `VLD_ADR_LEFT, 32'h0);
        chk("acks", 32'h2, {24'h0, acks});
        rdchk("window", `VLD_ADR_WINDOW, {16'h0, s[63:48]});
        wb(1'b1, `VLD_ADR_STATUS, 32'h8);
        rdchk("w1c", `VLD_ADR_STATUS, 32'h0);
        $display("test fetch done");
    endtask
    task t_shift;
        wb(1'b1, `VLD_ADR_CMD, 32'hf1);
        wait_st(`VLD_ST_DONE);
        rdchk("window", `VLD_ADR_WINDOW, {16'h0, s[48:33]});
        wb(1'b1, `VLD_ADR_IMASK, 32'h1);
        chk_irq(1'b1);
        wb(1'b1, `VLD_ADR_STATUS, 32'h1);
        rdchk("done kept", `VLD_ADR_STATUS, 32'h1);
        wb(1'b1, `VLD_ADR_IMASK, 32'h0);
        chk_irq(1'b0);
        $display("test shift done");
    endtask
    task t_parse;
        logic [31:0] e;
        hrdy <= 1'b0;
        wb(1'b1, `VLD_ADR_FETCH, 32'h108);
        wb(1'b1, `VLD_ADR_LEFT, 32'h8);
        wb(1'b1, `VLD_ADR_PINFO, 32'h3);
        wb(1'b1, `VLD_ADR_CMD, 32'h204);
        wait_st(`VLD_ST_OSTALL);
        chk("held", 32'h1, {31'h0, hval});
        e = hexp(15, 3);
        chk("hdr", e, hword);
        hrdy <= 1'b1;
        wait_st(`VLD_ST_DONE);
        $display("test parse done");
    endtask
    task t_start;
        gap <= 4'h0;
        wb(1'b1, `VLD_ADR_CMD, 32'h3);
        rdchk("imask", `VLD_ADR_IMASK, 32'h0);
        rdchk("fetch", `VLD_ADR_FETCH, 32'h0);
        wb(1'b1, `VLD_ADR_FETCH, 32'h200);
        wb(1'b1, `VLD_ADR_LEFT, 32'h4);
        wait_st(`VLD_ST_INDONE);
        rdchk("window", `VLD_ADR_WINDOW, 32'h0);
        wb(1'b1, `VLD_ADR_CMD, 32'h2);
        wait_st(`VLD_ST_DONE);
        wb(1'b1, `VLD_ADR_IMASK, 32'h2);
        wb(1'b1, `VLD_ADR_CMD, 32'h204);
        wait_st(`VLD_ST_START);
        chk_irq(1'b1);
        rdchk("code", `VLD_ADR_WINDOW, 32'h0);
        wb(1'b1, `VLD_ADR_QSCALE, 32'h1b);
        rdchk("qscale", `VLD_ADR_QSCALE, 32'h1b);
        wb(1'b1, `VLD_ADR_STATUS, 32'h2);
        chk_irq(1'b0);
        wb(1'b1, `VLD_ADR_CMD, 32'h5);
        wait_st(`VLD_ST_DONE);
        chk("flush", 32'h1, n_flush);
        $display("test start done");
    endtask
    initial
    begin
        repeat (30000) @(posedge clk_i);
        n_mismatch++;
        final_report;
    end
    initial
    begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {cyc, stb, we, adr, dat, gap} = '0;
        hrdy = 1'b1;
        s = {w(16'h0100), w(16'h0104)};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_fetch;
        t_shift;
        t_parse;
        t_start;
        final_report;
    end
endmodule // vld_top_tb_top
